// >>> src/pcc_pkg.sv
package pcc_pkg;

    // Register offsets
    localparam logic [7:0] REG_TGT_MSB = 8'h12;
    localparam logic [7:0] REG_TGT_LSB = 8'h13;
    localparam logic [7:0] REG_RAMP_CTL = 8'h14;
    localparam logic [7:0] REG_BUS_CFG = 8'h1A;
    localparam logic [7:0] REG_DOWN_MODE = 8'h1C;
    localparam logic [7:0] REG_BASE_ADDR = 8'h1E;
    localparam logic [7:0] REG_STATUS = 8'h1F;

    // Field positions
    localparam int BIT_BUS_LVL = 1;
    localparam int BIT_RAMP_FAST = 3;
    localparam int BIT_STOP_REQ = 2;
    localparam int BIT_DOWN_MODE = 3;

    // Values after reset
    localparam logic [7:0] RST_REG = 8'h00;
    localparam logic [7:0] RST_BASE_ADDR = 8'h08;

    // Stored-setting slots loaded after bias comes up
    localparam logic [2:0] NVM_SLOTS = 3'h6;

    // Ramp timing: one step per microsecond
    localparam int CLK_HZ = 10_000_000;
    localparam int RAMP_TICK_US = 1;
    localparam int TICK_CYC = CLK_HZ / 1_000_000 * RAMP_TICK_US;
    localparam logic [3:0] TICK_LAST = 4'(TICK_CYC - 1);

    // Reference in half-millivolt units
    localparam logic [13:0] STEP_SLOW = 14'h0001;
    localparam logic [13:0] STEP_FAST = 14'h0002;
    localparam logic [8:0] FINE_MAX_CODE = 9'h118;
    localparam logic [13:0] FINE_MULT = 14'h000A;
    localparam logic [13:0] FINE_OFFS = 14'h0320;
    localparam logic [13:0] COARSE_MULT = 14'h0014;
    localparam logic [13:0] COARSE_OFFS = 14'h0640;

    typedef enum logic [1:0] {
        SQ_WAIT = 2'b00,
        SQ_LOAD = 2'b01,
        SQ_STRAP = 2'b10,
        SQ_READY = 2'b11
    } pcc_seq_t;

    typedef enum logic [1:0] {
        CT_OFF = 2'b00,
        CT_ARM = 2'b01,
        CT_RUN = 2'b10,
        CT_STOP = 2'b11
    } pcc_ctl_t;

    typedef enum logic [2:0] {
        IS_IDLE = 3'b000,
        IS_ADDR = 3'b001,
        IS_PTR = 3'b010,
        IS_WR = 3'b011,
        IS_RD = 3'b100
    } pcc_i2c_t;

    typedef struct packed {
        logic en;
        logic [7:0] addr;
        logic [7:0] data;
    } pcc_wr_t;

    function automatic logic [13:0] tgt_level(input logic [8:0] code);
        logic [13:0] c;
        c = {5'h00, code};
        if (code <= FINE_MAX_CODE) begin
            tgt_level = 14'(c * FINE_MULT + FINE_OFFS);
        end else begin
            tgt_level = 14'(c * COARSE_MULT + COARSE_OFFS);
        end
    endfunction : tgt_level

endpackage : pcc_pkg

// >>> src/pcc_ramp.sv
`timescale 1ns/1ps
module pcc_ramp import pcc_pkg::*; (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic clear,
    input wire logic up,
    input wire logic down,
    input wire logic fast,
    input wire logic [13:0] target,
    output logic [13:0] level,
    output logic at_target,
    output logic at_zero
);

    logic [3:0] tick_cnt_r;
    logic tick;
    logic [13:0] step;

    assign tick = (tick_cnt_r == TICK_LAST);
    assign step = fast ? STEP_FAST : STEP_SLOW;
    assign at_target = (level == target);
    assign at_zero = (level == 14'h0000);

    always_ff @(posedge core_clk) begin
        if (rst || clear || tick) begin
            tick_cnt_r <= 4'h0;
        end else begin
            tick_cnt_r <= tick_cnt_r + 4'h1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst || clear) begin
            level <= 14'h0000;
        end else if (tick && up) begin
            if (level < target) begin
                level <= (target - level <= step) ? target : level + step;
            end else if (level > target) begin
                level <= (level - target <= step) ? target : level - step;
            end
        end else if (tick && down) begin
            level <= (level <= step) ? 14'h0000 : level - step;
        end
    end

endmodule : pcc_ramp

// >>> src/pcc_i2c_slave.sv
`timescale 1ns/1ps
module pcc_i2c_slave import pcc_pkg::*; (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic active,
    input wire logic [6:0] dev_addr,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    output logic [7:0] ptr,
    input wire logic [7:0] rd_data,
    output pcc_wr_t wr
);

    logic [1:0] scl_sy;
    logic [1:0] sda_sy;
    logic scl_d;
    logic sda_d;
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
    pcc_i2c_t st;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic in_ack;
    logic nack;
    logic rw;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            scl_sy <= 2'h3;
            sda_sy <= 2'h3;
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_sy <= {scl_sy[0], scl_in};
            sda_sy <= {sda_sy[0], sda_in};
            scl_d <= scl_sy[1];
            sda_d <= sda_sy[1];
        end
    end

    assign scl_rise = scl_sy[1] & ~scl_d;
    assign scl_fall = ~scl_sy[1] & scl_d;
    assign start = scl_sy[1] & scl_d & sda_d & ~sda_sy[1];
    assign stop = scl_sy[1] & scl_d & ~sda_d & sda_sy[1];

    // Open drain: only ever pulls low
    always_ff @(posedge core_clk) begin
        sda_out <= 1'b0;
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            st <= IS_IDLE;
            cnt <= 4'h0;
            sh <= 8'h00;
            in_ack <= 1'b0;
            nack <= 1'b0;
            rw <= 1'b0;
            sda_oe <= 1'b0;
            ptr <= 8'h00;
            wr <= '0;
        end else begin
            wr.en <= 1'b0;
            if (!active) begin
                st <= IS_IDLE;
                sda_oe <= 1'b0;
            end else if (start) begin
                st <= IS_ADDR;
                cnt <= 4'h0;
                in_ack <= 1'b0;
                sda_oe <= 1'b0;
            end else if (stop) begin
                st <= IS_IDLE;
                sda_oe <= 1'b0;
            end else if (st != IS_IDLE && scl_rise) begin
                if (in_ack) begin
                    nack <= sda_sy[1];
                    if (st == IS_RD && !sda_sy[1]) begin
                        ptr <= ptr + 8'h01;
                    end
                end else begin
                    sh <= {sh[6:0], sda_sy[1]};
                    cnt <= cnt + 4'h1;
                end
            end else if (st != IS_IDLE && scl_fall) begin
                if (!in_ack && cnt == 4'h8) begin
                    in_ack <= 1'b1;
                    case (st)
                        IS_ADDR: begin
                            if (sh[7:1] == dev_addr) begin
                                sda_oe <= 1'b1;
                                rw <= sh[0];
                            end else begin
                                st <= IS_IDLE;
                            end
                        end
                        IS_PTR: begin
                            ptr <= sh;
                            sda_oe <= 1'b1;
                        end
                        IS_WR: begin
                            wr.en <= 1'b1;
                            wr.addr <= ptr;
                            wr.data <= sh;
                            sda_oe <= 1'b1;
                        end
                        default: sda_oe <= 1'b0;
                    endcase
                end else if (in_ack) begin
                    in_ack <= 1'b0;
                    cnt <= 4'h0;
                    case (st)
                        IS_ADDR: begin
                            st <= rw ? IS_RD : IS_PTR;
                            sda_oe <= rw & ~rd_data[7];
                        end
                        IS_PTR: begin
                            st <= IS_WR;
                            sda_oe <= 1'b0;
                        end
                        IS_WR: begin
                            ptr <= ptr + 8'h01;
                            sda_oe <= 1'b0;
                        end
                        default: begin
                            st <= nack ? IS_IDLE : IS_RD;
                            sda_oe <= ~nack & ~rd_data[7];
                        end
                    endcase
                end else if (st == IS_RD) begin
                    sda_oe <= ~rd_data[3'h7 - cnt[2:0]];
                end
            end
        end
    end

endmodule : pcc_i2c_slave

// >>> src/pcc_ctrl.sv
`timescale 1ns/1ps
module pcc_ctrl import pcc_pkg::*; (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic bias_lockout_ok,
    input wire logic enable_pin,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic [2:0] addr_strap,
    output logic nvm_rd_en,
    output logic [2:0] nvm_addr,
    input wire logic [7:0] nvm_rdata,
    input wire logic feedback_pin_below_ref,
    input wire logic ocp_fault,
    input wire logic ovp_fault,
    output logic [13:0] ref_level,
    output logic high_side_drive,
    output logic low_side_drive,
    output logic first_pulse,
    output logic min_on_mode,
    output logic power_good_output,
    output logic [8:0] target_code,
    output logic bus_level_hi,
    output logic init_done
);

    ////////////////////////////////////////////////////////////////////////
    // Input synchronisers

    logic [1:0] bias_sy;
    logic [1:0] en_sy;
    logic [1:0] fb_sy;
    logic [1:0] ocp_sy;
    logic [1:0] ovp_sy;
    logic [2:0] strap_s1;
    logic [2:0] strap_s2;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            bias_sy <= 2'h0;
            en_sy <= 2'h0;
            fb_sy <= 2'h0;
            ocp_sy <= 2'h0;
            ovp_sy <= 2'h0;
            strap_s1 <= 3'h0;
            strap_s2 <= 3'h0;
        end else begin
            bias_sy <= {bias_sy[0], bias_lockout_ok};
            en_sy <= {en_sy[0], enable_pin};
            fb_sy <= {fb_sy[0], feedback_pin_below_ref};
            ocp_sy <= {ocp_sy[0], ocp_fault};
            ovp_sy <= {ovp_sy[0], ovp_fault};
            strap_s1 <= addr_strap;
            strap_s2 <= strap_s1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register file

    logic [7:0] target_code_msb_reg_r;
    logic [7:0] target_code_lsb_reg_r;
    logic [7:0] ramp_control_reg_r;
    logic [7:0] bus_level_config_reg_r;
    logic [7:0] ramp_down_mode_reg_r;
    logic [7:0] slave_base_addr_reg_r;
    logic [2:0] offset_r;
    logic [7:0] rd_ptr;
    logic [7:0] rd_data;
    pcc_wr_t bus_wr;
    pcc_wr_t nvm_wr;
    pcc_wr_t reg_wr;
    pcc_seq_t sq_r;
    pcc_ctl_t ct_r;

    // Bus is held silent during loading, so no collision
    assign reg_wr = nvm_wr.en ? nvm_wr : bus_wr;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            target_code_msb_reg_r <= RST_REG;
            target_code_lsb_reg_r <= RST_REG;
            ramp_control_reg_r <= RST_REG;
            bus_level_config_reg_r <= RST_REG;
            ramp_down_mode_reg_r <= RST_REG;
            slave_base_addr_reg_r <= RST_BASE_ADDR;
        end else if (reg_wr.en) begin
            if (reg_wr.addr == REG_TGT_MSB) begin
                target_code_msb_reg_r <= reg_wr.data;
            end else if (reg_wr.addr == REG_TGT_LSB) begin
                target_code_lsb_reg_r <= reg_wr.data;
            end else if (reg_wr.addr == REG_RAMP_CTL) begin
                ramp_control_reg_r <= reg_wr.data;
            end else if (reg_wr.addr == REG_BUS_CFG) begin
                bus_level_config_reg_r <= reg_wr.data;
            end else if (reg_wr.addr == REG_DOWN_MODE) begin
                ramp_down_mode_reg_r <= reg_wr.data;
            end else if (reg_wr.addr == REG_BASE_ADDR) begin
                slave_base_addr_reg_r <= reg_wr.data;
            end
        end
    end

    always_comb begin
        if (rd_ptr == REG_TGT_MSB) begin
            rd_data = target_code_msb_reg_r;
        end else if (rd_ptr == REG_TGT_LSB) begin
            rd_data = target_code_lsb_reg_r;
        end else if (rd_ptr == REG_RAMP_CTL) begin
            rd_data = ramp_control_reg_r;
        end else if (rd_ptr == REG_BUS_CFG) begin
            rd_data = bus_level_config_reg_r;
        end else if (rd_ptr == REG_DOWN_MODE) begin
            rd_data = ramp_down_mode_reg_r;
        end else if (rd_ptr == REG_BASE_ADDR) begin
            rd_data = slave_base_addr_reg_r;
        end else if (rd_ptr == REG_STATUS) begin
            rd_data = {init_done, power_good_output, high_side_drive,
                       ct_r, offset_r};
        end else begin
            rd_data = 8'h00;
        end
    end

    assign target_code = {target_code_msb_reg_r[0], target_code_lsb_reg_r};
    assign bus_level_hi = bus_level_config_reg_r[BIT_BUS_LVL];

    ////////////////////////////////////////////////////////////////////////
    // Initialisation sequencer

    logic [2:0] slot_r;
    logic ld_pend_r;

    function automatic logic [7:0] slot_addr(input logic [2:0] slot);
        case (slot)
            3'h0: slot_addr = REG_TGT_MSB;
            3'h1: slot_addr = REG_TGT_LSB;
            3'h2: slot_addr = REG_RAMP_CTL;
            3'h3: slot_addr = REG_BUS_CFG;
            3'h4: slot_addr = REG_DOWN_MODE;
            default: slot_addr = REG_BASE_ADDR;
        endcase
    endfunction : slot_addr

    assign nvm_addr = slot_r;
    assign nvm_wr.en = ld_pend_r;
    assign nvm_wr.addr = slot_addr(slot_r);
    assign nvm_wr.data = nvm_rdata;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            sq_r <= SQ_WAIT;
            slot_r <= 3'h0;
            nvm_rd_en <= 1'b0;
            ld_pend_r <= 1'b0;
            offset_r <= 3'h0;
            init_done <= 1'b0;
        end else begin
            nvm_rd_en <= 1'b0;
            ld_pend_r <= nvm_rd_en;
            if (!bias_sy[1]) begin
                // held in reset below bias start level
                sq_r <= SQ_WAIT;
                slot_r <= 3'h0;
                init_done <= 1'b0;
            end else begin
                case (sq_r)
                    SQ_WAIT: begin
                        sq_r <= SQ_LOAD;
                        slot_r <= 3'h0;
                    end
                    SQ_LOAD: begin
                        if (ld_pend_r) begin
                            slot_r <= slot_r + 3'h1;
                        end else if (!nvm_rd_en) begin
                            if (slot_r == NVM_SLOTS) begin
                                sq_r <= SQ_STRAP;
                            end else begin
                                nvm_rd_en <= 1'b1;
                            end
                        end
                    end
                    SQ_STRAP: begin
                        offset_r <= strap_s2;
                        sq_r <= SQ_READY;
                        init_done <= 1'b1;
                    end
                    default: begin
                        sq_r <= SQ_READY;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Serial bus slave

    logic [7:0] addr_sum;

    assign addr_sum = slave_base_addr_reg_r + {5'h00, offset_r};

    pcc_i2c_slave u_i2c (
        .core_clk(core_clk),
        .rst(rst),
        .active(init_done),
        .dev_addr(addr_sum[6:0]),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .sda_out(sda_out),
        .sda_oe(sda_oe),
        .ptr(rd_ptr),
        .rd_data(rd_data),
        .wr(bus_wr)
    );

    ////////////////////////////////////////////////////////////////////////
    // Start-up, run and shut-down control

    logic stop_req;
    logic go;
    logic ramp_clear;
    logic at_target;
    logic at_zero;

    // both bits needed for controlled stop
    assign stop_req = ramp_control_reg_r[BIT_STOP_REQ] &
                      ramp_down_mode_reg_r[BIT_DOWN_MODE];
    // faults cut the drive in any phase
    assign go = init_done & en_sy[1] & ~ocp_sy[1] & ~ovp_sy[1];
    // enable loss zeroes ramp at once
    assign ramp_clear = ~go | (ct_r == CT_OFF);

    pcc_ramp u_ramp (
        .core_clk(core_clk),
        .rst(rst),
        .clear(ramp_clear),
        .up((ct_r == CT_ARM) || (ct_r == CT_RUN)),
        .down(ct_r == CT_STOP),
        .fast(ramp_control_reg_r[BIT_RAMP_FAST]),
        .target(tgt_level(target_code)),
        .level(ref_level),
        .at_target(at_target),
        .at_zero(at_zero)
    );

    always_ff @(posedge core_clk) begin
        if (rst) begin
            ct_r <= CT_OFF;
            high_side_drive <= 1'b0;
            low_side_drive <= 1'b0;
            first_pulse <= 1'b0;
            min_on_mode <= 1'b0;
            power_good_output <= 1'b0;
        end else begin
            first_pulse <= 1'b0;
            if (!go) begin
                ct_r <= CT_OFF;
                high_side_drive <= 1'b0;
                low_side_drive <= 1'b0;
                min_on_mode <= 1'b0;
                power_good_output <= 1'b0;
            end else begin
                case (ct_r)
                    CT_OFF: begin
                        // start only once initialised and enabled
                        if (!stop_req) begin
                            ct_r <= CT_ARM;
                        end
                    end
                    CT_ARM: begin
                        if (fb_sy[1]) begin
                            ct_r <= CT_RUN;
                            high_side_drive <= 1'b1;
                            low_side_drive <= 1'b1;
                            first_pulse <= 1'b1;
                            min_on_mode <= 1'b1;
                        end else if (stop_req) begin
                            ct_r <= CT_OFF;
                        end
                    end
                    CT_RUN: begin
                        min_on_mode <= ~at_target;
                        power_good_output <= at_target;
                        if (stop_req) begin
                            ct_r <= CT_STOP;
                            power_good_output <= 1'b0;
                        end
                    end
                    default: begin
                        power_good_output <= 1'b0;
                        if (at_zero) begin
                            ct_r <= CT_OFF;
                            high_side_drive <= 1'b0;
                            low_side_drive <= 1'b0;
                            min_on_mode <= 1'b0;
                        end else if (!stop_req) begin
                            ct_r <= CT_RUN;
                        end
                    end
                endcase
            end
        end
    end

endmodule : pcc_ctrl

// >>> dv/pcc_far_side.sv
`timescale 1ns/1ps
module pcc_far_side import pcc_pkg::*; #(
    parameter logic [13:0] PREBIAS = 14'h0100
) (
    input wire logic core_clk,
    input wire logic nvm_rd_en,
    input wire logic [2:0] nvm_addr,
    output logic [7:0] nvm_rdata,
    input wire logic [13:0] ref_level,
    output logic feedback_pin_below_ref
);
    // Slots: 0x12, 0x13, 0x14, 0x1A, 0x1C, base
    logic [7:0] rom [0:5];
    assign rom = '{8'h00, 8'h05, 8'h08, 8'h02, 8'h08, 8'h20};
    // Idle data toggles so a late capture is not masked
    always_ff @(posedge core_clk) begin
        nvm_rdata <= nvm_rd_en ? rom[nvm_addr] : ~nvm_rdata;
    end
    // Output pre-charged to PREBIAS
    always_ff @(posedge core_clk) begin
        feedback_pin_below_ref <= ref_level > PREBIAS;
    end
endmodule : pcc_far_side

// >>> dv/pcc_ctrl_monitor.sv
`timescale 1ns/1ps
module pcc_ctrl_monitor import pcc_pkg::*; (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic bias_lockout_ok,
    input wire logic enable_pin,
    input wire logic sda_oe,
    input wire logic nvm_rd_en,
    input wire logic [13:0] ref_level,
    input wire logic high_side_drive,
    input wire logic low_side_drive,
    input wire logic min_on_mode,
    input wire logic power_good_output,
    input wire logic init_done
);
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (rst);
    a_early_ack: assert property (!init_done |-> !sda_oe)
        else $error("early ack");
    a_bias_drop: assert property (
        !bias_lockout_ok [*4] |-> !init_done)
        else $error("live without bias");
    a_load_first: assert property (nvm_rd_en |-> !init_done)
        else $error("load after init");
    a_ref_init: assert property (
        ref_level != 14'h0000 |-> $past(init_done))
        else $error("ramp before init");
    a_ramp_step: assert property (
        $changed(ref_level) && ref_level != 14'h0000
        |=> $stable(ref_level) [*8])
        else $error("ramp too fast");
    a_rise_ref: assert property (
        $rose(high_side_drive) |-> ref_level > 14'h0000)
        else $error("pulse at zero ramp");
    a_pg_rise: assert property (
        $rose(power_good_output) |-> high_side_drive)
        else $error("good before pulse");
    a_minon_drv: assert property (min_on_mode |-> high_side_drive)
        else $error("min on idle");
    a_off_enable: assert property (
        !enable_pin [*5] |-> !high_side_drive && !low_side_drive &&
        ref_level == 14'h0000)
        else $error("not off");
    a_stop_zero: assert property (
        $fell(high_side_drive) |-> ref_level == 14'h0000)
        else $error("off above zero");
endmodule : pcc_ctrl_monitor
bind pcc_ctrl pcc_ctrl_monitor u_mon (.core_clk, .rst, .bias_lockout_ok,
    .enable_pin, .sda_oe, .nvm_rd_en, .ref_level, .high_side_drive,
    .low_side_drive, .min_on_mode, .power_good_output, .init_done);

// >>> dv/tb.sv
`timescale 1ns/1ps
module tb import pcc_pkg::*; ();
    logic core_clk = 1'b0, rst = 1'b1, bias_lockout_ok = 1'b0;
    logic enable_pin = 1'b0, scl_in = 1'b1, sda_m = 1'b1;
    logic [2:0] addr_strap = 3'h3;
    logic sda_out, sda_oe, nvm_rd_en, first_pulse, min_on_mode;
    logic high_side_drive, low_side_drive, power_good_output;
    logic bus_level_hi, init_done, feedback_pin_below_ref;
    logic [2:0] nvm_addr;
    logic ocp_fault = 1'b0, ovp_fault = 1'b0;
    logic [7:0] nvm_rdata, rd;
    logic [13:0] ref_level, lvl;
    logic [8:0] target_code;
    int error_cnt = 0, samples_checked = 0;
    // Open-drain wire with pull-up
    wire sda_in = sda_m & ~(sda_oe & ~sda_out);

    pcc_ctrl dut (.core_clk, .rst, .bias_lockout_ok, .enable_pin, .scl_in,
        .sda_in, .sda_out, .sda_oe, .addr_strap, .nvm_rd_en, .nvm_addr,
        .nvm_rdata, .feedback_pin_below_ref, .ocp_fault,
        .ovp_fault, .ref_level, .high_side_drive, .low_side_drive,
        .first_pulse, .min_on_mode, .power_good_output, .target_code,
        .bus_level_hi, .init_done);
    pcc_far_side far (.core_clk, .nvm_rd_en, .nvm_addr, .nvm_rdata,
        .ref_level, .feedback_pin_below_ref);

    ////////////////////////////////////////
    task chk(input logic ok, input string m);
        samples_checked++;
        if (ok !== 1'b1) begin
            error_cnt++;
            $display("mismatch %0t %s", $time, m);
        end
    endtask : chk
    task wt(input int n);
        repeat (n) @(posedge core_clk);
    endtask : wt
    function automatic logic sig(input int s);
        case (s)
            0: sig = init_done;
            1: sig = first_pulse;
            2: sig = power_good_output;
            default: sig = !high_side_drive;
        endcase
    endfunction : sig
    // Sampled mid-cycle, away from the edge updates
    task wait_on(input int s);
        int n;
        n = 0;
        while (sig(s) !== 1'b1 && n < 9000) begin
            @(negedge core_clk);
            n++;
        end
        chk(n < 9000, "wait");
        wt(1);
    endtask : wait_on
    task i2c_start();
        sda_m <= 1'b0;
        wt(5);
        scl_in <= 1'b0;
        wt(5);
    endtask : i2c_start
    task i2c_stop();
        sda_m <= 1'b0;
        wt(5);
        scl_in <= 1'b1;
        wt(5);
        sda_m <= 1'b1;
        wt(5);
    endtask : i2c_stop
    // Ninth bit always released: a read byte ends with a NACK
    task i2c_byte(input logic [7:0] b, input logic ack,
            output logic [7:0] r);
        for (int k = 0; k < 9; k++) begin
            sda_m <= (k == 8) ? 1'b1 : b[7 - k];
            wt(5);
            scl_in <= 1'b1;
            wt(3);
            if (k < 8) begin
                r[7 - k] = sda_in;
            end else if (ack) begin
                chk(sda_oe === 1'b1, "no ack");
            end
            wt(2);
            scl_in <= 1'b0;
            wt(5);
        end
    endtask : i2c_byte
    // Device at base 0x20 plus strap 3
    task i2c_wr(input logic [7:0] p, input logic [7:0] d);
        logic [7:0] r;
        i2c_start();
        i2c_byte(8'h46, 1'b1, r);
        i2c_byte(p, 1'b1, r);
        i2c_byte(d, 1'b1, r);
        i2c_stop();
    endtask : i2c_wr
    task i2c_rd(input logic [7:0] p, output logic [7:0] d);
        logic [7:0] r;
        i2c_start();
        i2c_byte(8'h46, 1'b1, r);
        i2c_byte(p, 1'b1, r);
        i2c_stop();
        i2c_start();
        i2c_byte(8'h47, 1'b1, r);
        i2c_byte(8'hFF, 1'b0, d);
        i2c_stop();
    endtask : i2c_rd
    task summarize();
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : summarize

    initial begin
        forever #50 core_clk = ~core_clk;
    end
    initial begin
        #5_000_000;
        error_cnt++;
        summarize();
    end
    initial begin
        wt(2);
        rst <= 1'b0;
        wt(6);
        chk(init_done === 1'b0, "early init");
        bias_lockout_ok <= 1'b1;
        wait_on(0);
        chk(target_code === 9'h005, "code load");
        chk(bus_level_hi === 1'b1, "bus level");
        addr_strap <= 3'h0;
        i2c_wr(REG_TGT_LSB, 8'h07);
        chk(target_code === 9'h007, "code write");
        i2c_rd(REG_TGT_LSB, rd);
        chk(rd === 8'h07, "code read");
        i2c_rd(REG_STATUS, rd);
        chk(rd === 8'h83, "status");
        enable_pin <= 1'b1;
        wait_on(1);
        chk(ref_level > 14'h0100, "early pulse");
        wait_on(2);
        chk(ref_level === 14'h0366, "target");
        chk(min_on_mode === 1'b0 && low_side_drive === 1'b1, "ls on");
        i2c_wr(REG_RAMP_CTL, 8'h0C);
        wait_on(3);
        chk(ref_level === 14'h0000, "soft stop");
        i2c_wr(REG_RAMP_CTL, 8'h08);
        lvl = ref_level;
        wt(300);
        chk(ref_level - lvl === 14'h003C, "fast rate");
        i2c_wr(REG_RAMP_CTL, 8'h00);
        lvl = ref_level;
        wt(300);
        chk(ref_level - lvl === 14'h001E, "slow rate");
        ocp_fault <= 1'b1;
        wt(5);
        chk(ref_level === 14'h0000, "ocp off");
        ocp_fault <= 1'b0;
        wt(40);
        chk(ref_level !== 14'h0000, "restart");
        ovp_fault <= 1'b1;
        wt(5);
        chk(ref_level === 14'h0000, "ovp off");
        ovp_fault <= 1'b0;
        wt(40);
        enable_pin <= 1'b0;
        wt(5);
        chk(!high_side_drive && ref_level === 14'h0000, "hard off");
        summarize();
    end
endmodule : tb
